/* File: verilog/awsc_pkg.sv */
// Package with the map, fields, types and decode tables of the wait-state block
package awsc_pkg;

    localparam logic [31:0] ADDR_CONFIG = 32'h0000_0000;
    localparam logic [31:0] ADDR_MEMTYPE = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam logic [15:0] CONFIG_RESET = 16'hffff;
    localparam logic [2:0] MEMTYPE_RESET = 3'h0;

    localparam int AREA6_LSB = 13;
    localparam int AREA5_LSB = 10;
    localparam int AREA4_LSB = 7;
    localparam int AREA3_LSB = 5;
    localparam int AREA12_LSB = 3;
    localparam int AREA0_LSB = 0;

    // Memory type selection codes for areas 2 and 3
    localparam logic [2:0] MT_NORMAL = 3'h0;
    localparam logic [2:0] MT_A3_PSRAM = 3'h1;
    localparam logic [2:0] MT_A3_SDRAM = 3'h2;
    localparam logic [2:0] MT_A23_SDRAM = 3'h3;
    localparam logic [2:0] MT_A3_DRAM = 3'h4;
    localparam logic [2:0] MT_A23_DRAM = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_BURST = 3'b100
    } awsc_state_t;

    typedef struct packed {
        logic [2:0] area;
        logic [3:0] beats;
    } awsc_req_t;

    typedef struct packed {
        logic strobe_n;
        logic column_strobe;
        logic beat_done;
        logic access_done;
    } awsc_mem_t;

    function automatic logic [3:0] first_waits(input logic [2:0] code);
        case (code)
            3'h0: first_waits = 4'h0;
            3'h1: first_waits = 4'h1;
            3'h2: first_waits = 4'h2;
            3'h3: first_waits = 4'h3;
            3'h4: first_waits = 4'h4;
            3'h5: first_waits = 4'h6;
            3'h6: first_waits = 4'h8;
            default: first_waits = 4'ha;
        endcase
    endfunction : first_waits

    function automatic logic [3:0] burst_pitch(input logic [2:0] code);
        case (code)
            3'h0: burst_pitch = 4'h2;
            3'h1: burst_pitch = 4'h2;
            3'h2: burst_pitch = 4'h3;
            3'h3: burst_pitch = 4'h4;
            3'h4: burst_pitch = 4'h4;
            3'h5: burst_pitch = 4'h6;
            3'h6: burst_pitch = 4'h8;
            default: burst_pitch = 4'ha;
        endcase
    endfunction : burst_pitch

    function automatic logic [3:0] strobe_period(input logic [1:0] code);
        case (code)
            2'h0: strobe_period = 4'h1;
            2'h1: strobe_period = 4'h1;
            2'h2: strobe_period = 4'h2;
            default: strobe_period = 4'h3;
        endcase
    endfunction : strobe_period

endpackage : awsc_pkg

/* File: verilog/awsc_area_wait_state_control.sv */
// Wait-state register, AHB-Lite slave and per-area access timing sequencer
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module awsc_area_wait_state_control #(
    parameter int BEAT_W = 4
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic manual_reset,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic acc_valid,
    input wire awsc_pkg::awsc_req_t acc_req,
    output logic acc_ready,
    input wire logic ext_wait_n,
    output awsc_pkg::awsc_mem_t mem_out
);

    // Register file and bus state
    logic [15:0] area_wait_state_config;
    logic [15:0] next_config;
    logic [2:0] area23_memory_type_sel;
    logic [2:0] next_memtype;
    logic wr_pend;
    logic next_wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] next_wr_addr;
    logic [31:0] next_hrdata;

    // Sequencer state
    awsc_pkg::awsc_state_t state;
    awsc_pkg::awsc_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [BEAT_W-1:0] beats_left;
    logic [BEAT_W-1:0] next_beats_left;
    logic [2:0] area;
    logic [2:0] next_area;
    awsc_pkg::awsc_mem_t next_mem;

    // Wait pin synchroniser
    logic wait_meta;
    logic wait_sync;

    // Decoded timing for the active or requested area
    logic [2:0] sel_area;
    logic [2:0] code3;
    logic [1:0] code2;
    logic dram_type;
    logic has_pitch;
    logic wide_field;
    logic [3:0] first_cnt;
    logic [3:0] burst_cnt;
    logic wait_first_en;
    logic wait_burst_en;
    logic wait_hit;
    logic addr_phase;
    logic [15:0] merged_config;
    logic [2:0] merged_memtype;
    logic [31:0] status_word;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel & htrans[1] & hready;

    // Area select: request during idle, latched area while busy
    assign sel_area = (state == awsc_pkg::ST_IDLE) ? acc_req.area : area;

    always_comb
    begin
        code3 = 3'h0;
        code2 = 2'h0;
        wide_field = 1'b1;
        has_pitch = 1'b0;
        dram_type = 1'b0;
        case (sel_area)
            3'h0:
            begin
                code3 = area_wait_state_config[awsc_pkg::AREA0_LSB +: 3];
                has_pitch = 1'b1;
            end
            3'h1:
            begin
                code2 = area_wait_state_config[awsc_pkg::AREA12_LSB +: 2];
                wide_field = 1'b0;
            end
            3'h2:
            begin
                code2 = area_wait_state_config[awsc_pkg::AREA12_LSB +: 2];
                wide_field = 1'b0;
                dram_type = (area23_memory_type_sel == awsc_pkg::MT_A23_SDRAM) ||
                            (area23_memory_type_sel == awsc_pkg::MT_A23_DRAM);
            end
            3'h3:
            begin
                code2 = area_wait_state_config[awsc_pkg::AREA3_LSB +: 2];
                wide_field = 1'b0;
                dram_type = area23_memory_type_sel != awsc_pkg::MT_NORMAL;
            end
            3'h4:
            begin
                code3 = area_wait_state_config[awsc_pkg::AREA4_LSB +: 3];
            end
            3'h5:
            begin
                code3 = area_wait_state_config[awsc_pkg::AREA5_LSB +: 3];
                has_pitch = 1'b1;
            end
            default:
            begin
                code3 = area_wait_state_config[awsc_pkg::AREA6_LSB +: 3];
                has_pitch = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        if (dram_type)
        begin
            first_cnt = awsc_pkg::strobe_period(code2) - 4'h1;
        end
        else if (wide_field)
        begin
            first_cnt = awsc_pkg::first_waits(code3);
        end
        else
        begin
            first_cnt = {2'h0, code2};
        end
        if (has_pitch)
        begin
            burst_cnt = awsc_pkg::burst_pitch(code3) - 4'h1;
        end
        else
        begin
            burst_cnt = first_cnt;
        end
        if (dram_type)
        begin
            wait_first_en = 1'b0;
        end
        else if (wide_field)
        begin
            wait_first_en = code3 != 3'h0;
        end
        else
        begin
            wait_first_en = code2 != 2'h0;
        end
        wait_burst_en = has_pitch | wait_first_en;
    end

    // Wait pin lives outside the clock domain
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wait_meta <= 1'b1;
            wait_sync <= 1'b1;
        end
        else
        begin
            wait_meta <= ext_wait_n;
            wait_sync <= wait_meta;
        end
    end

    assign wait_hit = !wait_sync &&
                      ((state == awsc_pkg::ST_FIRST) ? wait_first_en : wait_burst_en);

    // Standby and manual reset refuse new accesses
    assign acc_ready = (state == awsc_pkg::ST_IDLE) && !standby && !manual_reset;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_beats_left = beats_left;
        next_area = area;
        next_mem = '{strobe_n: 1'b1, column_strobe: 1'b0, beat_done: 1'b0,
                     access_done: 1'b0};
        case (state)
            awsc_pkg::ST_IDLE:
            begin
                if (acc_valid && acc_ready)
                begin
                    next_state = awsc_pkg::ST_FIRST;
                    next_cnt = first_cnt;
                    next_area = acc_req.area;
                    next_beats_left = acc_req.beats[BEAT_W-1:0];
                    next_mem.strobe_n = 1'b0;
                    next_mem.column_strobe = dram_type;
                end
            end
            default:
            begin
                next_mem.strobe_n = 1'b0;
                next_mem.column_strobe = dram_type;
                if (cnt != 4'h0)
                begin
                    next_cnt = cnt - 4'h1;
                end
                else if (!wait_hit)
                begin
                    next_mem.beat_done = 1'b1;
                    if (beats_left == '0)
                    begin
                        next_state = awsc_pkg::ST_IDLE;
                        next_mem.strobe_n = 1'b1;
                        next_mem.column_strobe = 1'b0;
                        next_mem.access_done = 1'b1;
                    end
                    else
                    begin
                        next_state = awsc_pkg::ST_BURST;
                        next_cnt = burst_cnt;
                        next_beats_left = beats_left - 1'b1;
                    end
                end
            end
        endcase
        // Abort in flight: the cycle is lost, not resumed
        if (manual_reset || standby)
        begin
            next_state = awsc_pkg::ST_IDLE;
            next_mem.strobe_n = 1'b1;
            next_mem.column_strobe = 1'b0;
            next_mem.beat_done = 1'b0;
            next_mem.access_done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= awsc_pkg::ST_IDLE;
            cnt <= 4'h0;
            beats_left <= '0;
            area <= 3'h0;
            mem_out <= '{strobe_n: 1'b1, column_strobe: 1'b0, beat_done: 1'b0,
                         access_done: 1'b0};
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            beats_left <= next_beats_left;
            area <= next_area;
            mem_out <= next_mem;
        end
    end

    // Write forwarding keeps a read right after a write coherent
    always_comb
    begin
        merged_config = area_wait_state_config;
        merged_memtype = area23_memory_type_sel;
        next_config = area_wait_state_config;
        next_memtype = area23_memory_type_sel;
        if (wr_pend)
        begin
            if (wr_addr == awsc_pkg::ADDR_CONFIG)
            begin
                merged_config = hwdata[15:0];
            end
            // Reserved type codes cannot be set
            else if (wr_addr == awsc_pkg::ADDR_MEMTYPE && hwdata[2:0] <= awsc_pkg::MT_A23_DRAM)
            begin
                merged_memtype = hwdata[2:0];
            end
        end
        next_config = merged_config;
        next_memtype = merged_memtype;
    end

    assign status_word = {22'h0, mem_out.strobe_n, !wait_sync, beats_left[3:0],
                          area, state == awsc_pkg::ST_IDLE};

    always_comb
    begin
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        if (addr_phase)
        begin
            next_wr_addr = {haddr[31:2], 2'b00};
            if (!hwrite)
            begin
                if ({haddr[31:2], 2'b00} == awsc_pkg::ADDR_CONFIG)
                begin
                    next_hrdata = {16'h0, merged_config};
                end
                else if ({haddr[31:2], 2'b00} == awsc_pkg::ADDR_MEMTYPE)
                begin
                    next_hrdata = {29'h0, merged_memtype};
                end
                else if ({haddr[31:2], 2'b00} == awsc_pkg::ADDR_STATUS)
                begin
                    next_hrdata = status_word;
                end
                else
                begin
                    next_hrdata = 32'h0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            area_wait_state_config <= awsc_pkg::CONFIG_RESET;
            area23_memory_type_sel <= awsc_pkg::MEMTYPE_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 32'h0;
            hrdata <= 32'h0;
        end
        else
        begin
            area_wait_state_config <= next_config;
            area23_memory_type_sel <= next_memtype;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
        end
    end

endmodule : awsc_area_wait_state_control
`default_nettype wire

/* File: tb/awsc_chk_sva.sv */
// Port checker for the wait-state block
`timescale 1ns/1ps
`default_nettype none
module awsc_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic manual_reset,
    input wire logic standby,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic acc_valid,
    input wire logic acc_ready,
    input wire awsc_pkg::awsc_mem_t mem_out
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    bus_ready_a: assert property (hreadyout)
        else $error("bus not ready");
    resp_okay_a: assert property (!hresp)
        else $error("bus error response");
    busy_refuse_a: assert property (!mem_out.strobe_n |-> !acc_ready)
        else $error("request open while busy");
    start_strobe_a: assert property (acc_valid && acc_ready |=>
        !mem_out.strobe_n && !mem_out.beat_done) else $error("bad access start");
    done_pulse_a: assert property (mem_out.access_done |=> !mem_out.access_done)
        else $error("done longer than one cycle");
    done_beat_a: assert property (mem_out.access_done |->
        mem_out.beat_done && mem_out.strobe_n) else $error("done without last beat");
    standby_block_a: assert property (standby |-> !acc_ready)
        else $error("request open in standby");
    abort_end_a: assert property (manual_reset |=> mem_out.strobe_n)
        else $error("access not aborted");
    strobe_end_a: assert property ($rose(mem_out.strobe_n) |->
        mem_out.access_done || $past(manual_reset || standby)) else $error("early strobe end");
    column_inside_a: assert property (mem_out.column_strobe |-> !mem_out.strobe_n)
        else $error("column strobe outside access");

    cover property (acc_valid && acc_ready);
    cover property (mem_out.beat_done && !mem_out.access_done);
    cover property (mem_out.access_done);
    cover property (standby);
    cover property (mem_out.column_strobe);
endmodule : awsc_chk
bind awsc_area_wait_state_control awsc_chk u_chk (.sys_clk, .reset, .manual_reset,
    .standby, .hreadyout, .hresp, .acc_valid, .acc_ready, .mem_out);
`default_nettype wire

/* File: tb/awsc_mem_model.sv */
// External memory model that drives the wait pin
`timescale 1ns/1ps
`default_nettype none
module awsc_mem_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire awsc_pkg::awsc_mem_t mem_out,
    input wire logic [3:0] wait_len,
    output logic ext_wait_n
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    always_comb
    begin
        next_cnt = cnt;
        if (mem_out.strobe_n)
            next_cnt = 4'h0;
        else if (cnt != 4'hf)
            next_cnt = cnt + 4'h1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            cnt <= 4'h0;
        else
            cnt <= next_cnt;
    end

    // wait then release
    // Answers at once; released line rests high on its pull-up
    assign ext_wait_n = !(!mem_out.strobe_n && (cnt < wait_len));
endmodule : awsc_mem_model
`default_nettype wire

/* File: tb/awsc_area_wait_state_control_test.sv */
// Self-checking bench for the wait-state block
`timescale 1ns/1ps
`default_nettype none
module awsc_area_wait_state_control_test;
    logic sys_clk, reset, manual_reset, standby, hsel, hwrite, hreadyout, hresp;
    logic acc_valid, acc_ready, ext_wait_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] wait_len;
    logic col_seen;
    awsc_pkg::awsc_req_t acc_req;
    awsc_pkg::awsc_mem_t mem_out;
    int failures, check_count;
    int fw[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int bp[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
    int sp[4] = '{1, 1, 2, 3};

    awsc_area_wait_state_control dut (.sys_clk, .reset, .manual_reset, .standby, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp, .acc_valid, .acc_req, .acc_ready, .ext_wait_n, .mem_out);
    awsc_mem_model mem (.sys_clk, .reset, .mem_out, .wait_len, .ext_wait_n);

    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Sample before the edge so the answer is settled
    task automatic step();
        logic r;
        do
        begin
            @(negedge sys_clk);
            r = hreadyout;
            rd = hrdata;
            @(posedge sys_clk);
        end
        while (r !== 1'b1);
    endtask : step

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        step();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        step();
    endtask : bus

    task automatic access(input int area, input int beats, input logic [3:0] wl, output int n);
        logic r;
        wait_len <= wl;
        acc_valid <= 1'b1;
        acc_req <= {area[2:0], beats[3:0]};
        do
        begin
            @(negedge sys_clk);
            r = acc_ready;
            @(posedge sys_clk);
        end
        while (r !== 1'b1);
        acc_valid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
            if (n == 1)
                col_seen = mem_out.column_strobe;
            r = mem_out.access_done;
            @(posedge sys_clk);
        end
        while (r !== 1'b1 && n < 200);
    endtask : access

    function automatic int want(int area, int code, logic dram, int beats);
        int f;
        int p;
        f = dram ? sp[code] - 1 : (area inside {1, 2, 3}) ? code : fw[code];
        p = (area inside {0, 5, 6}) ? bp[code] : f + 1;
        return 2 + f + beats * p;
    endfunction : want

    task automatic run(int area, int code, logic dram);
        int n;
        int b;
        access(area, 2, 4'h0, n);
        check("access cycles", want(area, code, dram, 2), n);
        check("column strobe", dram, col_seen);
        access(area, 0, 4'h8, n);
        b = want(area, code, dram, 0);
        // Pin low 8 strobe cycles plus 2 sync stages: an honoured wait ends at 12
        // Beats ending before the synchronised pin turns low are not stretched
        if (dram || code == 0)
            check("wait ignored", b, n);
        else
            check("wait stretch", (b < 4 || b > 12) ? b : 12, n);
    endtask : run

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial
    begin
        #400000;
        failures++;
        give_verdict();
    end

    initial
    begin
        {reset, manual_reset, standby, hsel, hwrite, acc_valid} = 6'h20;
        {haddr, hwdata, htrans, acc_req} = '0;
        hsize = 3'h2;
        wait_len = 4'h0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, awsc_pkg::ADDR_CONFIG, 32'h0);
        check("config reset", 32'h0000_ffff, rd);
        bus(1'b1, awsc_pkg::ADDR_CONFIG, 32'hffff_a5c3);
        bus(1'b0, awsc_pkg::ADDR_CONFIG, 32'h0);
        check("config write", 32'h0000_a5c3, rd);
        manual_reset <= 1'b1;
        standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        manual_reset <= 1'b0;
        standby <= 1'b0;
        bus(1'b0, awsc_pkg::ADDR_CONFIG, 32'h0);
        check("config kept", 32'h0000_a5c3, rd);
        bus(1'b1, 32'h0000_000c, 32'h1234);
        bus(1'b0, 32'h0000_000c, 32'h0);
        check("unmapped read", 32'h0, rd);
        $display("test registers done");
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, awsc_pkg::ADDR_CONFIG, {16'h0, c[2:0], c[2:0], c[2:0], c[1:0], c[1:0], c[2:0]});
            for (int a = 0; a < 7; a++)
                run(a, (a inside {1, 2, 3}) ? c % 4 : c, 1'b0);
        end
        $display("test normal memory done");
        for (int t = 1; t < 6; t++)
        begin
            bus(1'b1, awsc_pkg::ADDR_MEMTYPE, t);
            for (int c = 0; c < 4; c++)
            begin
                bus(1'b1, awsc_pkg::ADDR_CONFIG, {25'h0, c[1:0], c[1:0], 3'h0});
                run(3, c, 1'b1);
                run(2, c, t == 3 || t == 5);
                run(1, c, 1'b0);
            end
        end
        bus(1'b1, awsc_pkg::ADDR_MEMTYPE, 32'h6);
        bus(1'b0, awsc_pkg::ADDR_MEMTYPE, 32'h0);
        check("memtype kept", 32'h5, rd);
        $display("test memory types done");
        bus(1'b1, awsc_pkg::ADDR_CONFIG, 32'hffff);
        acc_valid <= 1'b1;
        acc_req <= {3'h4, 4'h0};
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        standby <= 1'b1;
        @(negedge sys_clk);
        check("strobe before abort", 0, mem_out.strobe_n);
        @(negedge sys_clk);
        check("abort strobe", 1, mem_out.strobe_n);
        check("standby refuse", 0, acc_ready);
        @(posedge sys_clk);
        standby <= 1'b0;
        bus(1'b0, awsc_pkg::ADDR_CONFIG, 32'h0);
        check("config after abort", 32'h0000_ffff, rd);
        $display("test standby abort done");
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, awsc_pkg::ADDR_CONFIG, 32'h0);
        check("config reload", 32'h0000_ffff, rd);
        bus(1'b0, awsc_pkg::ADDR_STATUS, 32'h0);
        check("status idle", 32'h0000_0201, rd);
        $display("test second reset done");
        give_verdict();
    end
endmodule : awsc_area_wait_state_control_test
`default_nettype wire
